// ==== core/acp_pkg.sv ====
// Constants and types for the converter serial configuration port
package acp_pkg;
  // ************************************************************
  // Register addresses
  // ************************************************************
  localparam logic [12:0] ADDR_PORT_CFG = 13'h0000;
  localparam logic [12:0] ADDR_DEV_ID   = 13'h0001;
  localparam logic [12:0] ADDR_GRADE    = 13'h0002;
  localparam logic [12:0] ADDR_MODES    = 13'h0008;
  localparam logic [12:0] ADDR_UPDATE   = 13'h00FF;

  // ************************************************************
  // Reset values and fields
  // ************************************************************
  localparam logic [7:0] PORT_CFG_RST = 8'h18;
  localparam logic [7:0] MODES_RST    = 8'h00;
  localparam logic [7:0] UPDATE_RST   = 8'h00;
  localparam int CFG_LSB_HI  = 6;
  localparam int CFG_SRST_HI = 5;
  localparam int CFG_SRST_LO = 2;
  localparam int CFG_LSB_LO  = 1;
  localparam int UPD_COPY    = 0;
  localparam int PD_FUNC_BIT = 5;
  localparam int GRADE_LO    = 3;
  // Arbitrary identification value
  localparam logic [7:0] DEVICE_ID_VAL = 8'hA7;
  localparam logic [1:0] GRADE_CODE    = 2'h0;

  // ************************************************************
  // Frame layout
  // ************************************************************
  localparam logic [3:0] INSTR_LAST = 4'hF;
  localparam logic [2:0] BYTE_LAST  = 3'h7;
  localparam int RW_BIT  = 15;
  localparam int WL_HI   = 14;
  localparam int WL_LO   = 13;
  localparam logic [1:0] WL_STREAM = 2'h3;

  // ************************************************************
  // Power modes and output codes
  // ************************************************************
  localparam logic [2:0] PM_FULL_PD = 3'h1;
  localparam logic [2:0] PM_STANDBY = 3'h2;
  localparam logic [11:0] CODE_MIN  = 12'h000;
  localparam logic [11:0] CODE_MAX  = 12'hFFF;

  typedef enum logic [1:0] {PH_INSTR, PH_DATA, PH_DONE} acp_phase_t;
endpackage

// ==== core/acp_config_port.sv ====
// Serial configuration port, staged registers and output coding
`timescale 1ns/100ps
module acp_config_port
  import acp_pkg::*;
(
  input  wire logic        i_mclk,
  input  wire logic        i_rst_n,
  input  wire logic        i_serial_clock_or_format_strap,
  input  wire logic        i_port_select_n,
  input  wire logic        i_sdio_in,
  output logic             o_sdio_out,
  output logic             o_sdio_oe_n,
  input  wire logic        i_powerdown_pin,
  input  wire logic [11:0] i_conv_code,
  input  wire logic        i_conv_above,
  input  wire logic        i_conv_below,
  output logic      [11:0] o_data,
  output logic             o_out_of_range,
  output logic             o_twos_complement,
  output logic             o_full_powerdown,
  output logic             o_standby
);

  // ************************************************************
  // Serial clock domain: frame logic
  // ************************************************************
  logic        frame_rst_n;
  acp_phase_t  phase_q, phase_d;
  logic [3:0]  cnt_q, cnt_d;
  logic [2:0]  bcnt_q, bcnt_d;
  logic [15:0] sh_q, sh_d, sh_in;
  logic        rd_q, rd_d;
  logic [1:0]  wl_q, wl_d;
  logic [1:0]  left_q, left_d;
  logic [12:0] addr_q, addr_d;
  logic [7:0]  rdsh_q, rdsh_d, byte_in;
  logic        wr_en;
  logic        lsb_q, lsb_d;
  logic [7:0]  stg_q, stg_d, act_q, act_d;
  logic        tgl_q, tgl_d;
  logic        srst_wr;

  // Select high aborts any frame at once, even with the clock stopped
  assign frame_rst_n = i_rst_n & ~i_port_select_n;

  function automatic logic [7:0] read_byte(input logic [12:0] a);
    logic [7:0] r;
    r = 8'h00;
    if (a == ADDR_PORT_CFG)
    begin
      r = PORT_CFG_RST;
      r[CFG_LSB_HI] = lsb_q;
      r[CFG_LSB_LO] = lsb_q;
    end
    else if (a == ADDR_DEV_ID)
      r = DEVICE_ID_VAL;
    else if (a == ADDR_GRADE)
      r[GRADE_LO+1:GRADE_LO] = GRADE_CODE;
    else if (a == ADDR_MODES)
      r = stg_q;
    return r;
  endfunction

  always_comb
  begin
    phase_d = phase_q;
    cnt_d   = cnt_q;
    bcnt_d  = bcnt_q;
    rd_d    = rd_q;
    wl_d    = wl_q;
    left_d  = left_q;
    addr_d  = addr_q;
    rdsh_d  = rdsh_q;
    wr_en   = 1'b0;
    // Each order shifts in from its own end, so the whole frame lands the same way round
    sh_in   = lsb_q ? {i_sdio_in, sh_q[15:1]} : {sh_q[14:0], i_sdio_in};
    byte_in = lsb_q ? sh_in[15:8] : sh_in[7:0];
    sh_d    = sh_in;
    case (phase_q)
      PH_INSTR:
      begin
        cnt_d = cnt_q + 4'h1;
        if (cnt_q == INSTR_LAST)
        begin
          rd_d    = sh_in[RW_BIT];
          wl_d    = sh_in[WL_HI:WL_LO];
          left_d  = sh_in[WL_HI:WL_LO];
          addr_d  = sh_in[12:0];
          rdsh_d  = read_byte(sh_in[12:0]);
          bcnt_d  = 3'h0;
          phase_d = PH_DATA;
        end
      end
      PH_DATA:
      begin
        bcnt_d = bcnt_q + 3'h1;
        rdsh_d = lsb_q ? {1'b0, rdsh_q[7:1]} : {rdsh_q[6:0], 1'b0};
        if (bcnt_q == BYTE_LAST)
        begin
          wr_en  = ~rd_q;
          addr_d = lsb_q ? addr_q + 13'h0001 : addr_q - 13'h0001;
          rdsh_d = read_byte(addr_d);
          left_d = left_q - 2'h1;
          if (left_q == 2'h0 && wl_q != WL_STREAM)
            phase_d = PH_DONE;
        end
      end
      default:
      begin
        phase_d = PH_DONE;
      end
    endcase
  end

  // sampled on the rising edge from the first edge after select falls
  always_ff @(posedge i_serial_clock_or_format_strap or negedge frame_rst_n)
  begin
    if (!frame_rst_n)
    begin
      phase_q <= PH_INSTR;
      cnt_q   <= 4'h0;
      bcnt_q  <= 3'h0;
      sh_q    <= 16'h0000;
      rd_q    <= 1'b0;
      wl_q    <= 2'h0;
      left_q  <= 2'h0;
      addr_q  <= 13'h0000;
      rdsh_q  <= 8'h00;
    end
    else
    begin
      phase_q <= phase_d;
      cnt_q   <= cnt_d;
      bcnt_q  <= bcnt_d;
      sh_q    <= sh_d;
      rd_q    <= rd_d;
      wl_q    <= wl_d;
      left_q  <= left_d;
      addr_q  <= addr_d;
      rdsh_q  <= rdsh_d;
    end
  end

  // ************************************************************
  // Readback driver on the falling edge
  // ************************************************************
  logic sdio_out_d, sdio_oe_n_d;

  always_comb
  begin
    sdio_out_d  = lsb_q ? rdsh_q[0] : rdsh_q[7];
    sdio_oe_n_d = ~(phase_q == PH_DATA && rd_q);
  end

  always_ff @(negedge i_serial_clock_or_format_strap or negedge frame_rst_n)
  begin
    if (!frame_rst_n)
    begin
      o_sdio_out  <= 1'b0;
      o_sdio_oe_n <= 1'b1;
    end
    else
    begin
      o_sdio_out  <= sdio_out_d;
      o_sdio_oe_n <= sdio_oe_n_d;
    end
  end

  // ************************************************************
  // Serial clock domain: registers
  // ************************************************************
  always_comb
  begin
    lsb_d   = lsb_q;
    stg_d   = stg_q;
    act_d   = act_q;
    tgl_d   = tgl_q;
    srst_wr = wr_en && addr_q == ADDR_PORT_CFG
              && (byte_in[CFG_SRST_HI] || byte_in[CFG_SRST_LO]);
    if (srst_wr)
    begin
      // Soft reset bits are never stored, so they read back cleared
      lsb_d = PORT_CFG_RST[CFG_LSB_HI];
      stg_d = MODES_RST;
      act_d = MODES_RST;
      tgl_d = ~tgl_q;
    end
    else if (wr_en && addr_q == ADDR_PORT_CFG)
      lsb_d = byte_in[CFG_LSB_HI] | byte_in[CFG_LSB_LO];
    else if (wr_en && addr_q == ADDR_MODES)
      stg_d = byte_in;
    else if (wr_en && addr_q == ADDR_UPDATE && byte_in[UPD_COPY])
    begin
      act_d = stg_q;
      tgl_d = ~tgl_q;
    end
  end

  always_ff @(posedge i_serial_clock_or_format_strap or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      lsb_q <= PORT_CFG_RST[CFG_LSB_HI];
      stg_q <= MODES_RST;
      act_q <= MODES_RST;
      tgl_q <= 1'b0;
    end
    else
    begin
      lsb_q <= lsb_d;
      stg_q <= stg_d;
      act_q <= act_d;
      tgl_q <= tgl_d;
    end
  end

  // ************************************************************
  // Main clock domain: crossings, strap and power control
  // ************************************************************
  logic [2:0]  tgl_s_q, tgl_s_d;
  logic [1:0]  cs_s_q, cs_s_d, stp_s_q, stp_s_d, pd_s_q, pd_s_d;
  logic [7:0]  act_m_q, act_m_d;
  logic        used_q, used_d, fmt_q, fmt_d;
  logic [11:0] data_d;
  logic        oor_d, pd_d, sb_d;

  always_comb
  begin
    tgl_s_d = {tgl_s_q[1:0], tgl_q};
    cs_s_d  = {cs_s_q[0], i_port_select_n};
    stp_s_d = {stp_s_q[0], i_serial_clock_or_format_strap};
    pd_s_d  = {pd_s_q[0], i_powerdown_pin};
    // Active word is stable whenever the toggle edge is seen
    act_m_d = (tgl_s_q[2] != tgl_s_q[1]) ? act_q : act_m_q;
    used_d  = used_q | ~cs_s_q[1];
    // Strap is frozen once the port has carried a frame
    fmt_d   = used_q ? fmt_q : stp_s_q[1];
    data_d  = i_conv_code;
    if (i_conv_above)
      data_d = CODE_MAX;
    else if (i_conv_below)
      data_d = CODE_MIN;
    if (fmt_q)
      data_d[11] = ~data_d[11];
    oor_d = i_conv_above | i_conv_below;
    pd_d  = act_m_q[2:0] == PM_FULL_PD;
    sb_d  = act_m_q[2:0] == PM_STANDBY;
    if (pd_s_q[1])
    begin
      pd_d = pd_d | ~act_m_q[PD_FUNC_BIT];
      sb_d = sb_d | act_m_q[PD_FUNC_BIT];
    end
  end

  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      tgl_s_q           <= 3'h0;
      cs_s_q            <= 2'h3;
      stp_s_q           <= 2'h0;
      pd_s_q            <= 2'h0;
      act_m_q           <= MODES_RST;
      used_q            <= 1'b0;
      fmt_q             <= 1'b0;
      o_data            <= 12'h000;
      o_out_of_range    <= 1'b0;
      o_twos_complement <= 1'b0;
      o_full_powerdown  <= 1'b0;
      o_standby         <= 1'b0;
    end
    else
    begin
      tgl_s_q           <= tgl_s_d;
      cs_s_q            <= cs_s_d;
      stp_s_q           <= stp_s_d;
      pd_s_q            <= pd_s_d;
      act_m_q           <= act_m_d;
      used_q            <= used_d;
      fmt_q             <= fmt_d;
      o_data            <= data_d;
      o_out_of_range    <= oor_d;
      o_twos_complement <= fmt_q;
      o_full_powerdown  <= pd_d;
      o_standby         <= sb_d;
    end
  end

  // ************************************************************
  // Assertions
  // ************************************************************
  sequence s_instr_end;
    phase_q == PH_INSTR && cnt_q == INSTR_LAST;
  endsequence

  sequence s_copy_write;
    wr_en && !srst_wr && addr_q == ADDR_UPDATE && byte_in[UPD_COPY];
  endsequence

  sequence s_strap_high;
    (!used_q && stp_s_q[1]) [*2];
  endsequence

  a_instr_length: assert property (@(posedge i_serial_clock_or_format_strap)
    disable iff (!frame_rst_n) s_instr_end |=> phase_q == PH_DATA && bcnt_q == 3'h0)
    else $error("data phase did not follow 16 instruction bits");
  a_read_select: assert property (@(posedge i_serial_clock_or_format_strap)
    disable iff (!frame_rst_n) s_instr_end |=> rd_q == $past(sh_in[RW_BIT]))
    else $error("read flag not taken from first instruction bit");
  a_sdio_direction: assert property (@(posedge i_serial_clock_or_format_strap)
    disable iff (!frame_rst_n) o_sdio_oe_n == !(phase_q == PH_DATA && rd_q))
    else $error("data pin driven outside readback");
  a_staged_copy: assert property (@(posedge i_serial_clock_or_format_strap)
    disable iff (!i_rst_n) s_copy_write |=> act_q == $past(stg_q) && tgl_q != $past(tgl_q))
    else $error("transfer bit did not copy staged value");
  a_stage_only: assert property (@(posedge i_serial_clock_or_format_strap)
    disable iff (!i_rst_n) wr_en && addr_q == ADDR_MODES |=> $stable(act_q))
    else $error("function write reached active register directly");
  a_soft_reset: assert property (@(posedge i_serial_clock_or_format_strap)
    disable iff (!i_rst_n) srst_wr |=> !lsb_q && stg_q == MODES_RST && act_q == MODES_RST)
    else $error("soft reset did not restore defaults");
  a_strap_format: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    s_strap_high |-> ##2 o_twos_complement)
    else $error("strap high did not select twos complement");
  a_code_saturate: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    i_conv_above |=> o_out_of_range && o_data[10:0] == CODE_MAX[10:0])
    else $error("over range input not flagged and saturated");
  a_msb_invert: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    !i_conv_above && !i_conv_below |=> o_data == {$past(i_conv_code[11]) ^ $past(fmt_q),
      $past(i_conv_code[10:0])})
    else $error("output coding does not match format");
  a_full_powerdown: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    act_m_q[2:0] == PM_FULL_PD |=> o_full_powerdown)
    else $error("power mode 001 did not power down");
endmodule

// ==== testbench/acp_host_model.sv ====
// Host model that drives the serial configuration link
`timescale 1ns/100ps
module acp_host_model
(
  output logic      o_sclk,
  output logic      o_sel_n,
  output logic      o_sdio_out,
  output logic      o_sdio_oe_n,
  input  wire logic i_sdio
);
  logic lsb_first = 1'b0;

  initial
  begin
    o_sclk = 1'b0;
    o_sel_n = 1'b1;
    o_sdio_out = 1'b0;
    o_sdio_oe_n = 1'b1;
  end

  // Clock pin doubles as a static strap while the port is idle
  task automatic set_strap(input logic b);
    o_sclk = b;
  endtask

  task automatic put_bit(input logic b);
    o_sdio_out = b;
    #80;
    o_sclk = 1'b1;
    #80;
    o_sclk = 1'b0;
  endtask

  // ************************************************************
  // One frame: instruction, then nb data bits
  // ************************************************************
  task automatic xfer(input logic rd, input logic [12:0] a, input int nb,
                      input logic [15:0] wd, output logic [15:0] rdat);
    logic [15:0] ins;
    int          nbyt;
    int          idx;
    nbyt = (nb + 7) / 8;
    ins = {rd, 2'(nbyt - 1), a};
    rdat = 16'h0000;
    #7;
    o_sel_n = 1'b0;
    o_sdio_oe_n = 1'b0;
    #10;
    for (int i = 0; i < 16; i++)
    begin
      put_bit(lsb_first ? ins[i] : ins[15 - i]);
    end
    // Let go of the line before the device turns it round
    o_sdio_oe_n = rd;
    for (int i = 0; i < nb; i++)
    begin
      idx = 8 * (nbyt - 1 - i / 8) + (lsb_first ? i % 8 : 7 - i % 8);
      if (rd)
      begin
        #80;
        rdat[idx] = i_sdio;
        o_sclk = 1'b1;
        #80;
        o_sclk = 1'b0;
      end
      else
        put_bit(wd[idx]);
    end
    #10;
    o_sel_n = 1'b1;
    o_sdio_oe_n = 1'b1;
    #50;
  endtask
endmodule

// ==== testbench/testbench.sv ====
// Self-checking bench for the converter serial configuration port
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("mismatch %s expected %h seen %h", nm, e, g); end end
module testbench
  import acp_pkg::*;
;
  logic        i_mclk = 1'b0;
  logic        i_rst_n = 1'b0;
  logic        pd_pin = 1'b0;
  logic [11:0] conv_code = 12'h000;
  logic        above = 1'b0;
  logic        below = 1'b0;
  logic        flt = 1'b0;
  logic        sclk, sel_n, host_out, host_oe_n, dut_out, dut_oe_n, sdio;
  logic [11:0] data;
  logic        oor, tc, fpd, stby;
  int          num_errors = 0;
  int          n_checks = 0;

  always #10 i_mclk = ~i_mclk;
  // Released line toggles so a stale level never passes as data
  always @(posedge i_mclk) flt <= ~flt;
  assign sdio = !dut_oe_n ? dut_out : (!host_oe_n ? host_out : flt);

  acp_host_model i_host (.o_sclk(sclk), .o_sel_n(sel_n), .o_sdio_out(host_out),
    .o_sdio_oe_n(host_oe_n), .i_sdio(sdio));

  acp_config_port i_dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
    .i_serial_clock_or_format_strap(sclk), .i_port_select_n(sel_n), .i_sdio_in(sdio),
    .o_sdio_out(dut_out), .o_sdio_oe_n(dut_oe_n), .i_powerdown_pin(pd_pin),
    .i_conv_code(conv_code), .i_conv_above(above), .i_conv_below(below), .o_data(data),
    .o_out_of_range(oor), .o_twos_complement(tc), .o_full_powerdown(fpd), .o_standby(stby));

  function automatic logic [11:0] exp_code(input logic [11:0] c, input logic h,
                                           input logic l, input logic t);
    logic [11:0] v;
    v = h ? CODE_MAX : (l ? CODE_MIN : c);
    return {v[11] ^ t, v[10:0]};
  endfunction

  task automatic wr(input logic [12:0] a, input logic [7:0] d);
    logic [15:0] r;
    i_host.xfer(1'b0, a, 8, {8'h00, d}, r);
  endtask

  task automatic rdc(input logic [12:0] a, input logic [7:0] e, input logic [7:0] m);
    logic [15:0] r;
    i_host.xfer(1'b1, a, 8, 16'h0000, r);
    `CHK("register", e & m, r[7:0] & m)
  endtask

  task automatic conv_run(input logic t);
    logic [11:0] c;
    logic        h;
    logic        l;
    int          s;
    for (int k = 0; k < 24; k++)
    begin
      s = $urandom % 6;
      c = k == 0 ? 12'h000 : (k == 1 ? 12'h800 : (k == 2 ? 12'hFFF : 12'($urandom)));
      h = k == 3 || s == 0;
      l = !h && (k == 4 || s == 1);
      @(posedge i_mclk);
      conv_code <= c;
      above <= h;
      below <= l;
      @(posedge i_mclk);
      @(negedge i_mclk);
      `CHK("data", exp_code(c, h, l, t), data)
      `CHK("out_of_range", h | l, oor)
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial
  begin
    logic [15:0] r;
    logic [7:0]  mv;
    void'($urandom(32'hE0F6));
    // Past time zero, so the host's start-up idle level cannot override the strap
    @(posedge i_mclk);
    i_host.set_strap(1'b1);
    repeat (3) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    repeat (6) @(posedge i_mclk);
    @(negedge i_mclk);
    `CHK("twos_complement", 1'b1, tc)
    conv_run(1'b1);
    i_host.set_strap(1'b0);
    repeat (6) @(posedge i_mclk);
    @(negedge i_mclk);
    `CHK("twos_complement", 1'b0, tc)
    conv_run(1'b0);
    $display("test strap and coding done");
    rdc(ADDR_PORT_CFG, PORT_CFG_RST, 8'hFF);
    rdc(ADDR_DEV_ID, DEVICE_ID_VAL, 8'hFF);
    rdc(ADDR_GRADE, {3'h0, GRADE_CODE, 3'h0}, 8'hF8);
    rdc(ADDR_MODES, MODES_RST, 8'hFF);
    rdc(ADDR_UPDATE, UPDATE_RST, 8'hFF);
    rdc(13'h0005, 8'h00, 8'hFF);
    wr(ADDR_DEV_ID, 8'h5C);
    rdc(ADDR_DEV_ID, DEVICE_ID_VAL, 8'hFF);
    `CHK("sdio_oe_n", 1'b1, dut_oe_n)
    $display("test register map done");
    wr(ADDR_MODES, 8'h01);
    repeat (10) @(posedge i_mclk);
    @(negedge i_mclk);
    `CHK("staged_full_pd", 1'b0, fpd)
    rdc(ADDR_MODES, 8'h01, 8'hFF);
    for (int k = 0; k < 6; k++)
    begin
      mv = (k < 4) ? 8'(k) : {2'h0, k[0], 5'h00};
      @(posedge i_mclk);
      pd_pin <= (k >= 4);
      wr(ADDR_MODES, mv);
      wr(ADDR_UPDATE, 8'h01);
      repeat (10) @(posedge i_mclk);
      @(negedge i_mclk);
      `CHK("full_pd", (mv[2:0] == PM_FULL_PD) || (pd_pin && !mv[PD_FUNC_BIT]), fpd)
      `CHK("standby", (mv[2:0] == PM_STANDBY) || (pd_pin && mv[PD_FUNC_BIT]), stby)
    end
    rdc(ADDR_UPDATE, UPDATE_RST, 8'hFF);
    $display("test staged power modes done");
    wr(ADDR_MODES, 8'h00);
    i_host.xfer(1'b0, 13'h0009, 16, {8'h00, 8'h02}, r);
    rdc(ADDR_MODES, 8'h02, 8'hFF);
    i_host.xfer(1'b0, ADDR_MODES, 4, 16'h00FF, r);
    rdc(ADDR_MODES, 8'h02, 8'hFF);
    $display("test multibyte and abort done");
    wr(ADDR_PORT_CFG, 8'h5A);
    i_host.lsb_first = 1'b1;
    rdc(ADDR_PORT_CFG, 8'h5A, 8'hFF);
    wr(ADDR_MODES, 8'h03);
    rdc(ADDR_MODES, 8'h03, 8'hFF);
    // LSB first walks the address upwards, so the second byte lands on the modes register
    i_host.xfer(1'b0, 13'h0007, 16, {8'h00, 8'h06}, r);
    rdc(ADDR_MODES, 8'h06, 8'hFF);
    wr(ADDR_PORT_CFG, 8'h3C);
    i_host.lsb_first = 1'b0;
    rdc(ADDR_PORT_CFG, PORT_CFG_RST, 8'hFF);
    $display("test bit order and soft reset done");
    // Leave non-default state behind so the reset has something to undo
    wr(ADDR_MODES, 8'h05);
    wr(ADDR_PORT_CFG, 8'h5A);
    @(posedge i_mclk);
    i_rst_n <= 1'b0;
    conv_code <= 12'h000;
    above <= 1'b0;
    below <= 1'b0;
    @(negedge i_mclk);
    `CHK("data_in_reset", 12'h000, data)
    repeat (3) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    rdc(ADDR_MODES, MODES_RST, 8'hFF);
    rdc(ADDR_PORT_CFG, PORT_CFG_RST, 8'hFF);
    $display("test second reset done");
    end_of_test();
  end

  // Run needs about 160 us; far longer means a hang
  initial
  begin
    #400000;
    num_errors++;
    end_of_test();
  end
endmodule
